/* hw/tx_maint_pkg.sv */
// Constants, register map and field layout for the transmit maintenance signalling block
// Operation
// - Performance report only in T1/J1 mode with extended superframe framing.
// - Count line violations, CRC-6, frame errors, severe frame errors, slips each second.
// - With report enable set, build a report each second, send on data-link bits.
// - Send octets first to fourteenth, each octet from bit 1 to bit 8.
// - Command/response, R, U1, U2, loopback bits come from report control register.
// - Two sequence bits of each status pair come from a modulo-four counter.
// - Other bits of octets five to twelve encode event totals, zero by default.
// - At most one CRC grade bit per second, none for zero: 1, 2-5, 6-10, 11-100, 101-319, above.
// - Severe frame, frame, line violation, slip flags set when any such event occurred.
// - Bit message is repeating 17-bit pattern 111111110XXXXXX00 carrying six-bit code.
// - Bit message only in T1/J1 extended superframe and only when code not all ones.
// - Loopback code can be inserted into framed or unframed T1/J1 stream.
// - Loopback pattern eight bits, length two bits, inserted only while enabled.
// - Framed loopback overwrites all channel bits, framing bit left alone.
// - Unframed loopback overwrites channel bits and framing bit.
// - Final override: all ones on alarm bit, all zeros on disable; zeros win.
// - A change of alignment toggle bit deletes one stream bit; changes made before that deletion add none.
package tx_maint_pkg;

  localparam logic [7:0] LOOP_CTRL_OFS   = 8'h74;
  localparam logic [7:0] LOOP_PAT_OFS    = 8'h75;
  localparam logic [7:0] REPORT_CTRL_OFS = 8'h7F;
  localparam logic [7:0] BIT_MSG_OFS     = 8'h80;
  localparam logic [7:0] OVERRIDE_OFS    = 8'h6C;
  localparam logic [7:0] STATUS_OFS      = 8'h81;

  localparam logic [7:0] LOOP_CTRL_RST   = 8'h00;
  localparam logic [7:0] LOOP_PAT_RST    = 8'h00;
  localparam logic [7:0] REPORT_CTRL_RST = 8'h00;
  localparam logic [7:0] BIT_MSG_RST     = 8'h3F;
  localparam logic [7:0] OVERRIDE_RST    = 8'h00;

  // Loopback control fields
  localparam int LOOP_LEN_LSB   = 0;
  localparam int LOOP_EN_BIT    = 2;
  localparam int LOOP_UNFRM_BIT = 3;
  localparam logic [3:0] LOOP_LEN_BASE = 4'h5;
  // Report control fields
  localparam int REP_EN_BIT = 0;
  localparam int REP_CR_BIT = 1;
  localparam int REP_R_BIT  = 2;
  localparam int REP_U1_BIT = 3;
  localparam int REP_U2_BIT = 4;
  localparam int REP_LB_BIT = 5;
  // Override fields
  localparam int OVR_ONES_BIT   = 0;
  localparam int OVR_ZEROS_BIT  = 1;
  localparam int OVR_TOGGLE_BIT = 2;

  localparam logic [5:0] BIT_MSG_IDLE  = 6'h3F;
  localparam logic [4:0] BIT_MSG_LEN   = 5'h11;
  localparam logic [7:0] FLAG_OCTET    = 8'h7E;
  localparam logic [7:0] TEI_OCTET     = 8'h01;
  localparam logic [7:0] CTRL_OCTET    = 8'h03;
  localparam logic [5:0] SAPI_HI       = 6'h0E;
  localparam logic [6:0] REPORT_BITS   = 7'h70;
  localparam logic [15:0] FCS_POLY     = 16'h8408;
  localparam logic [15:0] FCS_INIT     = 16'hFFFF;

  localparam logic [8:0] GRADE2_MIN = 9'h002;
  localparam logic [8:0] GRADE3_MIN = 9'h006;
  localparam logic [8:0] GRADE4_MIN = 9'h00B;
  localparam logic [8:0] GRADE5_MIN = 9'h065;
  localparam logic [8:0] GRADE6_MIN = 9'h140;

  localparam int CLK_PERIOD_NS = 8;
  localparam int ONE_SEC_NS    = 1000000000;
  localparam int ONE_SEC_CYC   = ONE_SEC_NS / CLK_PERIOD_NS;

  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_WIDTH = 3;

endpackage

/* hw/tx_maint_signal.sv */
// Transmit maintenance signalling: bit FIFO and the per-link maintenance block
`timescale 1ns/1ps

module tx_bit_fifo #(
  parameter int WIDTH = 3,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_ff;
  logic [AW-1:0]    rdPtr_ff;
  logic [AW:0]      count_ff;
  logic [AW:0]      nxt_count;
  logic             doWr;
  logic             doRd;

  assign doWr     = inValid && inReady;
  assign doRd     = outValid && outReady;
  assign outValid = (count_ff != '0);
  assign outData  = mem[rdPtr_ff];

  always_comb begin
    nxt_count = count_ff;
    if (doWr && !doRd) begin
      nxt_count = count_ff + 1'b1;
    end else if (doRd && !doWr) begin
      nxt_count = count_ff - 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      count_ff <= '0;
      inReady  <= 1'b1;
    end else begin
      count_ff <= nxt_count;
      inReady  <= (nxt_count != (AW+1)'(DEPTH));
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
    end else begin
      if (doWr) wrPtr_ff <= wrPtr_ff + 1'b1;
      if (doRd) rdPtr_ff <= rdPtr_ff + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (doWr) mem[wrPtr_ff] <= inData;
  end
endmodule // tx_bit_fifo

module tx_maint_signal
  import tx_maint_pkg::*;
#(
  parameter int ONE_SEC_CYCLES = ONE_SEC_CYC
) (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrStb,
  input  wire logic       regRdStb,
  output logic      [7:0] regRdData,
  input  wire logic       t1Mode,
  input  wire logic       esfFraming,
  input  wire logic       lineViolEvt,
  input  wire logic       crcErrEvt,
  input  wire logic       frameErrEvt,
  input  wire logic       severeFrameErrEvt,
  input  wire logic       slipEvt,
  input  wire logic       txInValid,
  output logic            txInReady,
  input  wire logic       txInData,
  input  wire logic       txInFbit,
  input  wire logic       txInDlSlot,
  input  wire logic       lineTick,
  output logic            lineData,
  output logic            lineValid
);
  logic [7:0]   loopCtrl_ff;
  logic [7:0]   loopPat_ff;
  logic [7:0]   repCtrl_ff;
  logic [7:0]   bitMsg_ff;
  logic [7:0]   override_ff;
  logic         prevToggle_ff;
  logic         pendingDelete_ff;
  logic [31:0]  secCnt_ff;
  logic         secTick;
  logic [8:0]   crcCnt_ff;
  logic         lvSeen_ff;
  logic         feSeen_ff;
  logic         seSeen_ff;
  logic         slSeen_ff;
  logic [1:0]   seq_ff;
  logic [63:0]  hist_ff;
  logic [111:0] msg_ff;
  logic [6:0]   msgLeft_ff;
  logic [4:0]   bomIdx_ff;
  logic [2:0]   loopIdx_ff;
  logic         reportMode;
  logic         buildNow;
  logic [5:0]   grades;
  logic [15:0]  newPair;
  logic [87:0]  fcsBody;
  logic         fifoValid;
  logic         popReq;
  logic         popLine;
  logic         dropNow;
  logic [2:0]   fifoWord;
  logic         dataBit;
  logic         fBit;
  logic         dlBit;
  logic         bomOn;
  logic         loopOn;
  logic [3:0]   loopLen;
  logic         dlPath;
  logic         procBit;

  // CRC-CCITT frame check over the report body, sent low byte first
  function automatic logic [15:0] fcs16(input logic [87:0] body);
    logic [15:0] crc;
    logic        fb;
    crc = FCS_INIT;
    for (int i = 0; i < 88; i++) begin
      fb  = crc[0] ^ body[i];
      crc = {1'b0, crc[15:1]};
      if (fb) crc = crc ^ FCS_POLY;
    end
    return ~crc;
  endfunction

  // One bit of the repeating bit-oriented message pattern
  function automatic logic bomBit(input logic [5:0] code, input logic [4:0] idx);
    logic b;
    b = 1'b0;
    if (idx < 5'h08) begin
      b = 1'b1;
    end else if ((idx > 5'h08) && (idx < 5'h0F)) begin
      b = code[3'(idx - 5'h09)];
    end
    return b;
  endfunction

  // Register writes
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      loopCtrl_ff <= LOOP_CTRL_RST;
      loopPat_ff  <= LOOP_PAT_RST;
      repCtrl_ff  <= REPORT_CTRL_RST;
      bitMsg_ff   <= BIT_MSG_RST;
      override_ff <= OVERRIDE_RST;
    end else if (regWrStb) begin
      if (regAddr == LOOP_CTRL_OFS) begin
        loopCtrl_ff <= {4'h0, regWrData[3:0]};
      end else if (regAddr == LOOP_PAT_OFS) begin
        loopPat_ff <= regWrData;
      end else if (regAddr == REPORT_CTRL_OFS) begin
        repCtrl_ff <= {2'h0, regWrData[5:0]};
      end else if (regAddr == BIT_MSG_OFS) begin
        bitMsg_ff <= {2'h0, regWrData[5:0]};
      end else if (regAddr == OVERRIDE_OFS) begin
        override_ff <= {5'h00, regWrData[2:0]};
      end
    end
  end

  // Register reads, data in the following cycle; unmapped reads give zero
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      regRdData <= 8'h00;
    end else if (regRdStb) begin
      if (regAddr == LOOP_CTRL_OFS) begin
        regRdData <= loopCtrl_ff;
      end else if (regAddr == LOOP_PAT_OFS) begin
        regRdData <= loopPat_ff;
      end else if (regAddr == REPORT_CTRL_OFS) begin
        regRdData <= repCtrl_ff;
      end else if (regAddr == BIT_MSG_OFS) begin
        regRdData <= bitMsg_ff;
      end else if (regAddr == OVERRIDE_OFS) begin
        regRdData <= override_ff;
      end else if (regAddr == STATUS_OFS) begin
        regRdData <= {4'h0, seq_ff, bomOn, (msgLeft_ff != 7'h00)};
      end else begin
        regRdData <= 8'h00;
      end
    end else begin
      regRdData <= 8'h00;
    end
  end

  // One-second timebase
  assign secTick = (secCnt_ff == 32'(ONE_SEC_CYCLES - 1));
  always_ff @(posedge clk_sys) begin
    if (sys_rst || secTick) begin
      secCnt_ff <= 32'h0000_0000;
    end else begin
      secCnt_ff <= secCnt_ff + 32'h0000_0001;
    end
  end

  // Event counting; an event in the rollover cycle opens the new second
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      crcCnt_ff <= 9'h000;
      lvSeen_ff <= 1'b0;
      feSeen_ff <= 1'b0;
      seSeen_ff <= 1'b0;
      slSeen_ff <= 1'b0;
    end else if (secTick) begin
      crcCnt_ff <= {8'h00, crcErrEvt};
      lvSeen_ff <= lineViolEvt;
      feSeen_ff <= frameErrEvt;
      seSeen_ff <= severeFrameErrEvt;
      slSeen_ff <= slipEvt;
    end else begin
      if (crcErrEvt && (crcCnt_ff != 9'h1FF)) crcCnt_ff <= crcCnt_ff + 9'h001;
      if (lineViolEvt) lvSeen_ff <= 1'b1;
      if (frameErrEvt) feSeen_ff <= 1'b1;
      if (severeFrameErrEvt) seSeen_ff <= 1'b1;
      if (slipEvt) slSeen_ff <= 1'b1;
    end
  end

  // Grade of the CRC count; one bit at most, none when the count is zero
  always_comb begin
    grades = 6'h00;
    if (crcCnt_ff >= GRADE6_MIN) begin
      grades[5] = 1'b1;
    end else if (crcCnt_ff >= GRADE5_MIN) begin
      grades[4] = 1'b1;
    end else if (crcCnt_ff >= GRADE4_MIN) begin
      grades[3] = 1'b1;
    end else if (crcCnt_ff >= GRADE3_MIN) begin
      grades[2] = 1'b1;
    end else if (crcCnt_ff >= GRADE2_MIN) begin
      grades[1] = 1'b1;
    end else if (crcCnt_ff != 9'h000) begin
      grades[0] = 1'b1;
    end
  end

  // Status pair: high byte is the even octet, low byte the odd one
  assign newPair = {feSeen_ff, seSeen_ff, repCtrl_ff[REP_LB_BIT], grades[0],
                    repCtrl_ff[REP_R_BIT], grades[1], seq_ff[1], seq_ff[0],
                    grades[2], lvSeen_ff, grades[3], repCtrl_ff[REP_U1_BIT],
                    repCtrl_ff[REP_U2_BIT], grades[4], slSeen_ff, grades[5]};
  assign reportMode = t1Mode && esfFraming;
  assign buildNow   = secTick && repCtrl_ff[REP_EN_BIT] && reportMode;
  assign fcsBody    = {hist_ff[47:0], newPair, CTRL_OCTET, TEI_OCTET,
                       SAPI_HI, repCtrl_ff[REP_CR_BIT], 1'b0};

  // Report build: newest pair first, history shifts toward octet twelve
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      seq_ff  <= 2'b00;
      hist_ff <= 64'h0;
    end else if (buildNow) begin
      seq_ff  <= seq_ff + 2'b01;
      hist_ff <= {hist_ff[47:0], newPair};
    end
  end

  // Serialiser, least significant bit first; octet one in the low byte
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      msg_ff     <= 112'h0;
      msgLeft_ff <= 7'h00;
    end else if (buildNow) begin
      msg_ff     <= {fcs16(fcsBody),
                     fcsBody, FLAG_OCTET};
      msgLeft_ff <= REPORT_BITS;
    end else if (popLine && dlPath && (msgLeft_ff != 7'h00)) begin
      msg_ff     <= {1'b0, msg_ff[111:1]};
      msgLeft_ff <= msgLeft_ff - 7'h01;
    end
  end

  // Bit message position
  assign bomOn = reportMode && (bitMsg_ff[5:0] != BIT_MSG_IDLE);
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !bomOn) begin
      bomIdx_ff <= 5'h00;
    end else if (popLine && dlPath && (msgLeft_ff == 7'h00)) begin
      bomIdx_ff <= (bomIdx_ff == BIT_MSG_LEN - 5'h01) ? 5'h00 : bomIdx_ff + 5'h01;
    end
  end

  // Alignment toggle; a flip arms one deletion, a flip wins over the drop
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      prevToggle_ff    <= 1'b0;
      pendingDelete_ff <= 1'b0;
    end else begin
      prevToggle_ff <= override_ff[OVR_TOGGLE_BIT];
      if (override_ff[OVR_TOGGLE_BIT] != prevToggle_ff) begin
        pendingDelete_ff <= 1'b1;
      end else if (dropNow) begin
        pendingDelete_ff <= 1'b0;
      end
    end
  end

  tx_bit_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .inValid  (txInValid),
    .inReady  (txInReady),
    .inData   ({txInDlSlot, txInFbit, txInData}),
    .outValid (fifoValid),
    .outReady (popReq),
    .outData  (fifoWord)
  );

  assign dataBit = fifoWord[0];
  assign fBit    = fifoWord[1];
  assign dlBit   = fifoWord[2];
  assign popLine = lineTick && fifoValid;
  assign dropNow = pendingDelete_ff && fifoValid && !lineTick;
  assign popReq  = popLine || dropNow;
  assign dlPath  = reportMode && fBit && dlBit;
  assign loopOn  = t1Mode && loopCtrl_ff[LOOP_EN_BIT];
  assign loopLen = LOOP_LEN_BASE + {2'b00, loopCtrl_ff[LOOP_LEN_LSB +: 2]};

  // Data-link insertion, then loopback overwrite
  always_comb begin
    procBit = dataBit;
    if (dlPath && (msgLeft_ff != 7'h00)) begin
      procBit = msg_ff[0];
    end else if (dlPath && bomOn) begin
      procBit = bomBit(bitMsg_ff[5:0], bomIdx_ff);
    end
    if (loopOn && (loopCtrl_ff[LOOP_UNFRM_BIT] || !fBit)) begin
      procBit = loopPat_ff[3'(loopLen - 4'h1 - {1'b0, loopIdx_ff})];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst || !loopOn) begin
      loopIdx_ff <= 3'h0;
    end else if (popLine && (loopCtrl_ff[LOOP_UNFRM_BIT] || !fBit)) begin
      loopIdx_ff <= ({1'b0, loopIdx_ff} == loopLen - 4'h1) ? 3'h0 : loopIdx_ff + 3'h1;
    end
  end

  // Line output with final overrides
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      lineData  <= 1'b0;
      lineValid <= 1'b0;
    end else begin
      lineValid <= popLine;
      if (popLine) begin
        if (override_ff[OVR_ZEROS_BIT]) begin
          lineData <= 1'b0;
        end else if (override_ff[OVR_ONES_BIT]) begin
          lineData <= 1'b1;
        end else begin
          lineData <= procBit;
        end
      end
    end
  end

  sequence s_build;
    buildNow;
  endsequence
  sequence s_flip;
    override_ff[OVR_TOGGLE_BIT] != prevToggle_ff;
  endsequence

  property p_report_mode;
    @(posedge clk_sys) disable iff (sys_rst) $rose(msgLeft_ff != 7'h00) |-> $past(t1Mode && esfFraming);
  endproperty
  a_report_mode: assert property (p_report_mode) else $error("report started outside ESF T1");

  property p_report_load;
    @(posedge clk_sys) disable iff (sys_rst) s_build |=> (msgLeft_ff == 7'h70) && (msg_ff[7:0] == 8'h7E);
  endproperty
  a_report_load: assert property (p_report_load) else $error("report not loaded");

  property p_seq_step;
    @(posedge clk_sys) disable iff (sys_rst) s_build |=> (seq_ff == $past(seq_ff) + 2'b01) && (hist_ff[8] == $past(seq_ff[0]));
  endproperty
  a_seq_step: assert property (p_seq_step) else $error("sequence count wrong");

  property p_one_grade;
    @(posedge clk_sys) disable iff (sys_rst) s_build and (crcCnt_ff != 9'h000)
      |=> $onehot({hist_ff[0], hist_ff[2], hist_ff[5], hist_ff[7], hist_ff[10], hist_ff[12]});
  endproperty
  a_one_grade: assert property (p_one_grade) else $error("CRC grade not unique");

  property p_slip_flag;
    @(posedge clk_sys) disable iff (sys_rst) s_build and slSeen_ff |=> hist_ff[1];
  endproperty
  a_slip_flag: assert property (p_slip_flag) else $error("slip flag missing");

  property p_zeros;
    @(posedge clk_sys) disable iff (sys_rst) popLine && override_ff[OVR_ZEROS_BIT] |=> lineValid && !lineData;
  endproperty
  a_zeros: assert property (p_zeros) else $error("all zeros not applied");

  property p_ones;
    @(posedge clk_sys) disable iff (sys_rst)
      popLine && override_ff[OVR_ONES_BIT] && !override_ff[OVR_ZEROS_BIT] |=> lineValid && lineData;
  endproperty
  a_ones: assert property (p_ones) else $error("all ones not applied");

  property p_delete;
    @(posedge clk_sys) disable iff (sys_rst) s_flip |=> pendingDelete_ff;
  endproperty
  a_delete: assert property (p_delete) else $error("alignment change not armed");

  property p_framed_fbit;
    @(posedge clk_sys) disable iff (sys_rst) popLine && loopOn && !loopCtrl_ff[LOOP_UNFRM_BIT] && fBit && !dlPath
      && (override_ff[1:0] == 2'b00) |=> lineData == $past(dataBit);
  endproperty
  a_framed_fbit: assert property (p_framed_fbit) else $error("framing bit overwritten");
endmodule // tx_maint_signal

/* bench/line_sink.sv */
// Line-side partner: asks the block for bits and records every bit it hands out
`timescale 1ns/1ps
module line_sink (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic tickEn,
  input  wire logic slowMode,
  input  wire logic lineData,
  input  wire logic lineValid,
  output logic      lineTick
);
  logic bits[$];

  // Slow mode asks for a bit on about one cycle in three
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      lineTick <= 1'b0;
    end else begin
      lineTick <= tickEn && (!slowMode || ($urandom_range(2) == 0));
      if (lineValid === 1'b1) begin
        bits.push_back(lineData);
      end
    end
  end
endmodule // line_sink

/* bench/tx_maint_signal_tb.sv */
// Self-checking bench for the transmit maintenance block
`timescale 1ns/1ps
module tx_maint_signal_tb;
  import tx_maint_pkg::*;
  localparam int SEC = 500;
  logic       clk_sys = 1'b0, sys_rst = 1'b1, regWrStb = 1'b0, regRdStb = 1'b0, t1Mode = 1'b1, esfFraming = 1'b0;
  logic       lineViolEvt = 1'b0, crcErrEvt = 1'b0, frameErrEvt = 1'b0, severeFrameErrEvt = 1'b0, slipEvt = 1'b0;
  logic       txInValid = 1'b0, txInData = 1'b0, txInFbit = 1'b0, txInDlSlot = 1'b0, tickEn = 1'b1, slowMode = 1'b0;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, rv, rctl;
  logic       txInReady, lineTick, lineData, lineValid, feedOn = 1'b0;
  logic       inD[$], inF[$], pat[$];
  int         error_cnt = 0, cmp_count = 0;

  always #4 clk_sys = ~clk_sys;

  tx_maint_signal #(.ONE_SEC_CYCLES(SEC)) u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .t1Mode(t1Mode),
    .esfFraming(esfFraming), .lineViolEvt(lineViolEvt), .crcErrEvt(crcErrEvt), .frameErrEvt(frameErrEvt),
    .severeFrameErrEvt(severeFrameErrEvt), .slipEvt(slipEvt), .txInValid(txInValid), .txInReady(txInReady),
    .txInData(txInData), .txInFbit(txInFbit), .txInDlSlot(txInDlSlot), .lineTick(lineTick), .lineData(lineData),
    .lineValid(lineValid));
  line_sink u_sink (.clk_sys(clk_sys), .sys_rst(sys_rst), .tickEn(tickEn), .slowMode(slowMode),
    .lineData(lineData), .lineValid(lineValid), .lineTick(lineTick));

  // Endless zero data-link bits for the report test
  always @(posedge clk_sys) begin
    if (feedOn) begin
      {txInValid, txInData, txInFbit, txInDlSlot} <= 4'hB;
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("comparisons=%0d mismatches=%0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    {regAddr, regWrData, regWrStb} <= {a, d, 1'b1};
    @(posedge clk_sys);
    regWrStb <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    {regAddr, regRdStb} <= {a, 1'b1};
    @(posedge clk_sys);
    regRdStb <= 1'b0;
    @(posedge clk_sys);
    chk({8'h00, regRdData}, {8'h00, e});
  endtask

  task automatic send(input int n, input int fe, input logic dl);
    logic d, f;
    for (int i = 0; i < n; i++) begin
      d = 1'($urandom_range(1));
      f = (fe > 0) && (i % fe == 0);
      inD.push_back(d);
      inF.push_back(f);
      {txInValid, txInData, txInFbit, txInDlSlot} <= {1'b1, d, f, dl & f};
      do @(posedge clk_sys); while (txInReady !== 1'b1);
    end
    txInValid <= 1'b0;
  endtask

  task automatic drain();
    for (int n = 0; n < 600 && u_sink.bits.size() < inD.size(); n++) @(posedge clk_sys);
  endtask

  task automatic clr();
    u_sink.bits.delete();
    inD.delete();
    inF.delete();
  endtask

  // Mode 0 passes data through, 1 all zeros, 2 all ones
  task automatic cmpq(input int m);
    drain();
    chk(16'(u_sink.bits.size()), 16'(inD.size()));
    foreach (inD[i]) chk(16'(u_sink.bits[i]), (m == 0) ? 16'(inD[i]) : 16'(m == 2));
    clr();
  endtask

  // Output must repeat pat at some phase; framing bits kept when skipF
  task automatic perq(input bit skipF);
    logic s[$];
    bit   ok, hit;
    drain();
    hit = 1'b0;
    foreach (inD[i]) begin
      if (skipF && inF[i]) chk(16'(u_sink.bits[i]), 16'(inD[i]));
      else s.push_back(u_sink.bits[i]);
    end
    for (int ph = 0; ph < pat.size(); ph++) begin
      ok = (s.size() > 0);
      foreach (s[i]) if (s[i] !== pat[(i + ph) % pat.size()]) ok = 1'b0;
      hit |= ok;
    end
    chk(16'(hit), 16'h0001);
    clr();
  endtask

  task automatic evts(input int c, input int v, input int f, input int s, input int l);
    for (int i = 0; i < c || i < 3; i++) begin
      {crcErrEvt, lineViolEvt, frameErrEvt, severeFrameErrEvt, slipEvt} <= {i < c, i < v, i < f, i < s, i < l};
      @(posedge clk_sys);
    end
    {crcErrEvt, lineViolEvt, frameErrEvt, severeFrameErrEvt, slipEvt} <= 5'h00;
  endtask

  // Status pair as {second octet, first octet}
  function automatic logic [15:0] pair(input int c, input int v, input int f, input int s, input int l,
                                       input logic [1:0] q);
    logic [5:0] g;
    g = {c >= 320, c > 100 && c < 320, c > 10 && c <= 100, c > 5 && c <= 10, c > 1 && c <= 5, c == 1};
    return {f > 0, s > 0, rctl[REP_LB_BIT], g[0], rctl[REP_R_BIT], g[1], q,
            g[2], v > 0, g[3], rctl[REP_U1_BIT], rctl[REP_U2_BIT], g[4], l > 0, g[5]};
  endfunction

  function automatic logic [15:0] fcs(input logic [7:0] o [14]);
    logic [15:0] c;
    c = FCS_INIT;
    for (int i = 1; i < 12; i++) begin
      for (int b = 0; b < 8; b++) begin
        c = (c[0] ^ o[i][b]) ? ((c >> 1) ^ FCS_POLY) : (c >> 1);
      end
    end
    return ~c;
  endfunction

  task automatic report_test();
    int          s, p, ev[6][5];
    int          cnt[6] = '{1, 5, 10, 100, 319, 320};
    logic [7:0]  o [14];
    logic [15:0] prev;
    rctl = 8'(($urandom() & 32'h3E) | 32'h1);
    wr(REPORT_CTRL_OFS, rctl);
    feedOn <= 1'b1;
    repeat (2 * SEC) @(posedge clk_sys);
    foreach (u_sink.bits[i]) chk(16'(u_sink.bits[i]), 16'h0000);
    esfFraming <= 1'b1;
    u_sink.bits.delete();
    p = 0;
    for (int k = 0; k < 7; k++) begin
      s = -1;
      for (int n = 0; n < 6 * SEC && s < 0; n++) begin
        if (p < u_sink.bits.size()) begin
          if (u_sink.bits[p] === 1'b1) s = p - 1;
          p++;
        end else begin
          @(posedge clk_sys);
        end
      end
      if (k < 6) begin
        ev[k][0] = cnt[k];
        for (int j = 1; j < 5; j++) ev[k][j] = $urandom_range(3);
        evts(ev[k][0], ev[k][1], ev[k][2], ev[k][3], ev[k][4]);
      end
      for (int n = 0; n < 400 && u_sink.bits.size() < s + 112; n++) @(posedge clk_sys);
      foreach (o[i]) for (int b = 0; b < 8; b++) o[i][b] = u_sink.bits[s + 8 * i + b];
      chk({o[0], o[1]}, {FLAG_OCTET, 6'h0E, rctl[REP_CR_BIT], 1'b0});
      chk({o[2], o[3]}, 16'h0103);
      if (k > 0) begin
        chk({o[5], o[4]}, pair(ev[k-1][0], ev[k-1][1], ev[k-1][2], ev[k-1][3], ev[k-1][4], prev[9:8] + 2'h1));
        chk({o[7], o[6]}, prev);
      end
      chk({o[13], o[12]}, fcs(o));
      prev = {o[5], o[4]};
      p = s + 112;
    end
    $display("report test done");
  endtask

  initial begin
    int   n;
    logic d;
    rv = 8'($urandom(32'h3f7d4288));
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    rd(LOOP_CTRL_OFS, 8'h00);
    rd(REPORT_CTRL_OFS, 8'h00);
    rd(BIT_MSG_OFS, 8'h3F);
    rd(OVERRIDE_OFS, 8'h00);
    rd(8'h10, 8'h00);
    rd(STATUS_OFS, 8'h00);
    wr(LOOP_PAT_OFS, rv);
    rd(LOOP_PAT_OFS, rv);
    wr(BIT_MSG_OFS, 8'hFF);
    rd(BIT_MSG_OFS, 8'h3F);
    $display("register test done");
    for (int m = 1; m >= 0; m--) begin
      wr(OVERRIDE_OFS, 8'(2 * m + 1));
      send(24, 6, 1'b0);
      cmpq(2 - m);
    end
    for (int t = 0; t < 2; t++) begin
      tickEn <= 1'b0;
      repeat (2) @(posedge clk_sys);
      wr(OVERRIDE_OFS, 8'(4 - 4 * t));
      send(24, 0, 1'b0);
      tickEn <= 1'b1;
      drain();
      chk(16'(u_sink.bits.size()), 16'h0017);
      n = 0;
      foreach (u_sink.bits[i]) begin
        if (u_sink.bits[i] !== inD[i + n]) n++;
        if (u_sink.bits[i] !== inD[i + n]) n = 9;
      end
      chk(16'(n), 16'h0001);
      clr();
    end
    $display("override test done");
    for (int c = 0; c < 4; c++) begin
      rv = 8'($urandom());
      pat.delete();
      for (int j = 0; j < 5 + c; j++) pat.push_back(rv[4 + c - j]);
      wr(LOOP_PAT_OFS, rv);
      wr(LOOP_CTRL_OFS, 8'(4 + c + 8 * (c % 2)));
      send(60, 7, 1'b0);
      perq(c % 2 == 0);
    end
    wr(LOOP_CTRL_OFS, 8'h00);
    send(24, 7, 1'b0);
    cmpq(0);
    $display("loopback test done");
    esfFraming <= 1'b1;
    rv = 8'($urandom_range(62));
    wr(BIT_MSG_OFS, rv);
    pat = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    for (int j = 0; j < 6; j++) pat.push_back(rv[j]);
    pat.push_back(1'b0);
    pat.push_back(1'b0);
    send(68, 1, 1'b1);
    perq(1'b0);
    esfFraming <= 1'b0;
    send(24, 1, 1'b1);
    cmpq(0);
    esfFraming <= 1'b1;
    wr(BIT_MSG_OFS, 8'h3F);
    send(24, 1, 1'b1);
    cmpq(0);
    $display("bit message test done");
    {t1Mode, esfFraming, tickEn} <= 3'h0;
    repeat (2) @(posedge clk_sys);
    n = 0;
    d = 1'($urandom_range(1));
    {txInValid, txInData, txInFbit} <= {1'b1, d, 1'b0};
    repeat (40) begin
      @(posedge clk_sys);
      if (txInReady === 1'b1) begin
        inD.push_back(d);
        n++;
        d = 1'($urandom_range(1));
        txInData <= d;
      end
    end
    txInValid <= 1'b0;
    chk(16'(n), 16'h0020);
    {tickEn, slowMode} <= 2'h3;
    cmpq(0);
    {t1Mode, slowMode} <= 2'h2;
    $display("buffer test done");
    report_test();
    finish_test();
  end

  initial begin
    repeat (40000) @(posedge clk_sys);
    error_cnt++;
    finish_test();
  end
endmodule // tx_maint_signal_tb
